// file: bench/sdg_chan_model.sv
`timescale 1ns/10ps
`default_nettype none
module sdg_chan_model (
	input wire logic cmd, // channel command
	input wire logic matched_mem_command, // matched memory command
	output logic chanCommand // combined command to the glue
);
	// wide processor build: plain or of both commands
	assign chanCommand = cmd | matched_mem_command;
endmodule
`default_nettype wire

// file: bench/sdg_glue_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module sdg_glue_monitor (
	input wire logic sys_clk, // system clock
	input wire logic resetn, // async reset, low
	input wire sdg_pkg::sdg_bus_s cpuBus, // local bus cycle
	input wire logic cpuOwnsBus, // processor is master
	input wire logic cpuGenAddr, // processor drives address
	input wire logic chanSetupCycle, // channel setup cycle
	input wire logic [15:0] setupPtr, // setup pointer value
	input wire logic [7:0] videoEnReg, // video enable register
	input wire logic [7:0] sysCtrlA, // system control port a
	input wire logic [7:0] memEncReg, // memory encoding register
	input wire logic testN, // test pin
	input wire logic addrGateStrapOut, // gate pin output side
	input wire logic addrGateStrapOe, // gate pin drive enable
	input wire logic video_window_sel, // video window decode
	input wire logic setup_data_reg_sel, // setup data decode
	input wire logic card_setup_sel, // card setup decode
	input wire logic phys_addr_bit20, // gated address bit 20
	input wire logic parity_check_en_out, // parity check enable
	input wire sdg_pkg::sdg_bus_s latchedBus, // captured bus state
	input wire logic latchArmed, // latching enabled
	input wire logic outputsOe // drive enable
);
	// cycle and range qualifiers
	wire logic [31:0] addr = cpuBus.addr;
	wire logic memCyc = cpuBus.cycleValid & cpuBus.mio & cpuBus.dc;
	wire logic ioCyc = cpuBus.cycleValid & ~cpuBus.mio & cpuBus.dc
		& (addr[31:16] == 16'h0000);
	wire logic inWin = (addr >= sdg_pkg::VID_BASE)
		&& (addr <= sdg_pkg::VID_LAST);
	wire logic inCard = (addr[15:0] >= sdg_pkg::CARD_BASE)
		&& (addr[15:0] <= sdg_pkg::CARD_LAST);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence s_test_low;
		!testN [*6];
	endsequence
	sequence s_test_high;
		testN [*8];
	endsequence

	property p_vid_dis;
		!videoEnReg[0] |=> !video_window_sel;
	endproperty
	a_vid_dis: assert property (p_vid_dis)
		else $error("video sel while off");
	property p_vid_hit;
		videoEnReg[0] && memCyc && inWin |=> video_window_sel;
	endproperty
	a_vid_hit: assert property (p_vid_hit)
		else $error("video sel missing");
	property p_vid_miss;
		!inWin |=> !video_window_sel;
	endproperty
	a_vid_miss: assert property (p_vid_miss)
		else $error("video sel outside");
	property p_setup;
		ioCyc && (addr[15:0] == setupPtr) |=> setup_data_reg_sel;
	endproperty
	a_setup: assert property (p_setup)
		else $error("setup sel missing");
	property p_card;
		ioCyc && chanSetupCycle && inCard |=> card_setup_sel;
	endproperty
	a_card: assert property (p_card)
		else $error("card sel missing");
	property p_parity;
		1'b1 |=> parity_check_en_out == $past(memEncReg[0]);
	endproperty
	a_parity: assert property (p_parity)
		else $error("parity enable wrong");
	property p_bit20_pass;
		!cpuGenAddr |=> phys_addr_bit20 == $past(cpuBus.addr[20]);
	endproperty
	a_bit20_pass: assert property (p_bit20_pass)
		else $error("bit20 gated");
	property p_alt_gate;
		sysCtrlA[1] && cpuOwnsBus |=> addrGateStrapOut;
	endproperty
	a_alt_gate: assert property (p_alt_gate)
		else $error("alt gate lost");
	property p_no_latch;
		!latchArmed |=> $stable(latchedBus);
	endproperty
	a_no_latch: assert property (p_no_latch)
		else $error("capture unarmed");
	property p_test_off;
		s_test_low |-> !outputsOe && !addrGateStrapOe;
	endproperty
	a_test_off: assert property (p_test_off)
		else $error("drive in test");
	property p_test_on;
		s_test_high |-> outputsOe;
	endproperty
	a_test_on: assert property (p_test_on)
		else $error("no drive");
endmodule

bind sdg_glue sdg_glue_monitor i_mon (.sys_clk, .resetn, .cpuBus,
	.cpuOwnsBus, .cpuGenAddr, .chanSetupCycle, .setupPtr, .videoEnReg,
	.sysCtrlA, .memEncReg, .testN, .addrGateStrapOut, .addrGateStrapOe,
	.video_window_sel, .setup_data_reg_sel, .card_setup_sel,
	.phys_addr_bit20, .parity_check_en_out, .latchedBus, .latchArmed,
	.outputsOe);
`default_nettype wire

// file: bench/sdg_glue_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sdg_glue_tb;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	sdg_pkg::sdg_bus_s cpuBus = '0;
	logic cpuOwnsBus = 1'b0, cpuGenAddr = 1'b0, chanSetupCycle = 1'b1;
	logic [15:0] setupPtr = 16'h0700;
	logic [7:0] videoEnReg = 8'h01, sysCtrlA = 8'h00, memEncReg = 8'h00;
	logic chan_reset_in = 1'b0, chan_check_in = 1'b0, cmd = 1'b0;
	logic matched_mem_command = 1'b0, kbc_addr_gate_in = 1'b0, chan_master_in = 1'b0;
	logic testN = 1'b1, strapDrv = 1'b1;
	logic chan_command_in, addrGateStrapIn, addrGateStrapOut;
	logic addrGateStrapOe, video_window_sel, setup_data_reg_sel;
	logic card_setup_sel, phys_addr_bit20, parity_check_en_out;
	logic latchedValid, latchArmed, outputsOe;
	logic [1:0] speedSel;
	sdg_pkg::sdg_bus_s latchedBus;
	int n_errors = 0;
	int samples_checked = 0;

	always #5 sys_clk = ~sys_clk;
	// gate pin: design drives when enabled, else the strap source
	assign addrGateStrapIn = addrGateStrapOe ? addrGateStrapOut : strapDrv;

	sdg_chan_model i_chan (.cmd(cmd), .matched_mem_command(matched_mem_command),
		.chanCommand(chan_command_in));
	sdg_glue i_dut (.sys_clk, .resetn, .cpuBus, .cpuOwnsBus, .cpuGenAddr,
		.chanSetupCycle, .setupPtr, .videoEnReg, .sysCtrlA, .memEncReg,
		.chan_reset_in, .chan_check_in, .chan_command_in, .kbc_addr_gate_in,
		.chan_master_in, .testN, .addrGateStrapIn, .addrGateStrapOut,
		.addrGateStrapOe, .video_window_sel, .setup_data_reg_sel,
		.card_setup_sel, .phys_addr_bit20, .parity_check_en_out, .speedSel,
		.latchedBus, .latchedValid, .latchArmed, .outputsOe);

	////////////////////////////////////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic mio, input logic [31:0] a);
		cpuBus = {1'b1, mio, 1'b1, 1'b0, a};
	endtask
	// one decode cycle, selects as {video, setup, card}
	task automatic dec(input logic mio, input logic [31:0] a,
		input logic [2:0] e);
		bus(mio, a);
		step(1);
		chk({video_window_sel, setup_data_reg_sel, card_setup_sel}, e);
	endtask
	task automatic t_strap(input logic s, input logic m);
		resetn = 1'b0;
		strapDrv = s;
		chan_master_in = m;
		step(8);
		resetn = 1'b1;
		step(10);
		chk(speedSel, {s, m});
		chk(addrGateStrapOe, 1'b1);
		chk(outputsOe, 1'b1);
	endtask
	task automatic t_decode;
		dec(1'b1, 32'h000a0000, 3'h4);
		dec(1'b1, 32'h000bffff, 3'h4);
		dec(1'b1, 32'h000c0000, 3'h0);
		dec(1'b1, 32'h0009ffff, 3'h0);
		dec(1'b0, 32'h00000700, 3'h2);
		dec(1'b0, 32'h00000100, 3'h1);
		dec(1'b0, 32'h00000107, 3'h1);
		dec(1'b0, 32'h00000108, 3'h0);
		chanSetupCycle = 1'b0;
		dec(1'b0, 32'h00000100, 3'h0);
		chanSetupCycle = 1'b1;
		videoEnReg = 8'h00;
		dec(1'b1, 32'h000a0000, 3'h0);
		memEncReg = 8'h01;
		step(2);
		chk(parity_check_en_out, 1'b1);
		memEncReg = 8'h00;
		step(2);
		chk(parity_check_en_out, 1'b0);
	endtask
	task automatic t_gate;
		kbc_addr_gate_in = 1'b1;
		cpuGenAddr = 1'b1;
		bus(1'b1, 32'h00100000);
		step(8);
		chk(addrGateStrapOut, 1'b1);
		chk(phys_addr_bit20, 1'b1);
		kbc_addr_gate_in = 1'b0;
		step(8);
		chk(addrGateStrapOut, 1'b0);
		chk(phys_addr_bit20, 1'b0);
		cpuGenAddr = 1'b0;
		step(2);
		chk(phys_addr_bit20, 1'b1);
		sysCtrlA = 8'h02;
		cpuOwnsBus = 1'b1;
		step(2);
		chk(addrGateStrapOut, 1'b1);
		cpuOwnsBus = 1'b0;
		step(2);
		chk(addrGateStrapOut, 1'b0);
	endtask
	task automatic t_latch;
		sdg_pkg::sdg_bus_s snap;
		bus(1'b1, 32'h12345678);
		snap = cpuBus;
		chan_reset_in = 1'b1;
		step(8);
		chan_reset_in = 1'b0;
		chk(latchArmed, 1'b1);
		cmd = 1'b1;
		step(10);
		chk(latchedBus, snap);
		chk(latchedValid, 1'b1);
		cmd = 1'b0;
		chan_check_in = 1'b1;
		step(8);
		bus(1'b0, 32'h00000abc);
		chk(latchArmed, 1'b0);
		matched_mem_command = 1'b1;
		step(10);
		chk(latchedBus, snap);
		matched_mem_command = 1'b0;
		chan_check_in = 1'b0;
	endtask
	task automatic t_test;
		testN = 1'b0;
		step(8);
		chk(outputsOe, 1'b0);
		chk(addrGateStrapOe, 1'b0);
		testN = 1'b1;
		step(8);
		chk(outputsOe, 1'b1);
		chk(addrGateStrapOe, 1'b1);
	endtask
	task automatic results;
		$display("errors=%0d checks=%0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence, second reset flips the straps
	initial begin
		t_strap(1'b1, 1'b0);
		t_decode;
		t_gate;
		t_latch;
		t_test;
		t_strap(1'b0, 1'b1);
		results;
	end
	// watchdog against a hang
	initial begin
		#20000;
		n_errors++;
		results;
	end
endmodule
`default_nettype wire

// file: rtl/sdg_glue.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R1: video window select only acts while video enable bit 0 is set.
// R2: video select asserts for memory addresses 000a0000 through 000bffff.
// R3: setup data select lets the pointed setup register be read or written.
// R4: setup data select asserts when io address equals setup pointer value.
// R5: card setup select for io 0100h-0107h during channel setup cycles.
// R6: channel reset enables latching of local bus state.
// R7: channel check stops all further latching of local bus state; here a channel reset after check is released arms latching again.
// R8: outside logic drives command as OR of commands, inverted if narrow.
// R9: with latching enabled, capture state on command leading edge.
// R10: gate physical address bit 20 whenever processor generates address.
// R11: gate pin is input at power-on, latched with master at reset end.
// R12: speed select comes from the two latched strap values.
// R13: after power-on the gate pin becomes the address gate output.
// R14: gate active on keyboard gate, or alternate bit with processor bus.
// R15: parity check enable follows bit 0 of memory encoding register.
// R16: test input low tristates every output and two-way line.
// R17: test input high enables outputs for normal operation.
// R18: video select stays inactive outside window or when disabled.
module sdg_glue (
	input wire logic sys_clk, // system clock, 100 MHz
	input wire logic resetn, // async reset, low
	input wire sdg_pkg::sdg_bus_s cpuBus, // local bus cycle
	input wire logic cpuOwnsBus, // processor is master
	input wire logic cpuGenAddr, // processor drives address
	input wire logic chanSetupCycle, // channel setup cycle
	input wire logic [15:0] setupPtr, // setup pointer value
	input wire logic [7:0] videoEnReg, // video enable register
	input wire logic [7:0] sysCtrlA, // system control port a
	input wire logic [7:0] memEncReg, // memory encoding register
	input wire logic chan_reset_in, // channel reset pin
	input wire logic chan_check_in, // channel check pin
	input wire logic chan_command_in, // channel command pin
	input wire logic kbc_addr_gate_in, // keyboard gate pin
	input wire logic chan_master_in, // channel master strap
	input wire logic testN, // test pin, low tristates
	input wire logic addrGateStrapIn, // gate pin input side
	output logic addrGateStrapOut, // gate pin output side
	output logic addrGateStrapOe, // gate pin drive enable
	output logic video_window_sel, // video window decode
	output logic setup_data_reg_sel, // setup data decode
	output logic card_setup_sel, // card setup decode
	output logic phys_addr_bit20, // gated address bit 20
	output logic parity_check_en_out, // parity check enable
	output logic [1:0] speedSel, // latched speed straps
	output sdg_pkg::sdg_bus_s latchedBus, // captured bus state
	output logic latchedValid, // a capture is held
	output logic latchArmed, // latching enabled
	output logic outputsOe // drive enable, all outputs
);
	////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [sdg_pkg::PIN_W-1:0] pinRaw, pinLvl, pinRise;

	// gather pins into one vector for the sync chain
	assign pinRaw[sdg_pkg::PIN_CHRST] = chan_reset_in;
	assign pinRaw[sdg_pkg::PIN_CHAN_CHECK_IN] = chan_check_in;
	assign pinRaw[sdg_pkg::PIN_CMD] = chan_command_in;
	assign pinRaw[sdg_pkg::PIN_KBC] = kbc_addr_gate_in;
	assign pinRaw[sdg_pkg::PIN_STRAP] = addrGateStrapIn;
	assign pinRaw[sdg_pkg::PIN_MSTR] = chan_master_in;
	assign pinRaw[sdg_pkg::PIN_TEST] = testN;

	sdg_pin_sync #(
		.W(sdg_pkg::PIN_W),
		.RST_VAL(sdg_pkg::PIN_RST_VAL)
	) uPinSync (
		.sysClk(sys_clk),
		.resetn(resetn),
		.pinIn(pinRaw),
		.level(pinLvl),
		.rise(pinRise)
	);

	////////////////////////////////////////////////////////////////////
	// address decodes

	logic memCycle, ioCycle, vidHit, setupHit, cardHit;
	logic videoSel_q, videoSel_d;
	logic setupSel_q, setupSel_d;
	logic cardSel_q, cardSel_d;

	// cycle type from the status lines
	assign memCycle = cpuBus.cycleValid & cpuBus.mio & cpuBus.dc;
	assign ioCycle = cpuBus.cycleValid & ~cpuBus.mio & cpuBus.dc;

	// window compares
	always_comb begin
		vidHit = (cpuBus.addr >= sdg_pkg::VID_BASE) &&
			(cpuBus.addr <= sdg_pkg::VID_LAST); // [R2]
		setupHit = (cpuBus.addr[31:16] == 16'h0000) &&
			(cpuBus.addr[15:0] == setupPtr); // [R4]
		cardHit = (cpuBus.addr[31:16] == 16'h0000) &&
			(cpuBus.addr[15:0] >= sdg_pkg::CARD_BASE) &&
			(cpuBus.addr[15:0] <= sdg_pkg::CARD_LAST);
	end

	// next values of the decode outputs
	always_comb begin
		videoSel_d = memCycle & vidHit &
			videoEnReg[sdg_pkg::VID_EN_BIT]; // [R1] [R18]
		setupSel_d = ioCycle & setupHit; // [R3]
		cardSel_d = ioCycle & cardHit & chanSetupCycle; // [R5]
	end

	// decode registers, one cycle after the address
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			videoSel_q <= 1'b0;
			setupSel_q <= 1'b0;
			cardSel_q <= 1'b0;
		end else begin
			videoSel_q <= videoSel_d;
			setupSel_q <= setupSel_d;
			cardSel_q <= cardSel_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// local bus state latching

	logic armed_q, armed_d, capture;

	// check wins over reset, so a fault freezes the snapshot
	always_comb begin
		armed_d = armed_q;
		if (pinLvl[sdg_pkg::PIN_CHRST]) begin
			armed_d = 1'b1; // [R6]
		end
		if (pinLvl[sdg_pkg::PIN_CHAN_CHECK_IN]) begin
			armed_d = 1'b0; // [R7]
		end
	end

	// latch enable register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			armed_q <= 1'b0;
		end else begin
			armed_q <= armed_d;
		end
	end

	// command is taken active high, already combined outside [R8]
	assign capture = armed_q & ~pinLvl[sdg_pkg::PIN_CHAN_CHECK_IN] &
		pinRise[sdg_pkg::PIN_CMD]; // [R9]

	sdg_state_capture #(
		.W(sdg_pkg::BUS_W)
	) uCapture (
		.sysClk(sys_clk),
		.resetn(resetn),
		.capture(capture),
		.dataIn(cpuBus),
		.dataOut(latchedBus),
		.valid(latchedValid)
	);

	////////////////////////////////////////////////////////////////////
	// power-on straps and address gate

	sdg_pkg::sdg_strap_e strap_q, strap_d;
	logic [2:0] settle_q, settle_d;
	logic [1:0] speed_q, speed_d;
	logic gateOn, gate_q, gate_d;
	logic bit20_q, bit20_d;

	// wait for the sync chain to fill, then take the straps once
	always_comb begin
		strap_d = strap_q;
		settle_d = settle_q;
		speed_d = speed_q;
		unique case (strap_q)
			sdg_pkg::ST_SETTLE: begin
				if (settle_q == sdg_pkg::STRAP_SETTLE_CYC) begin
					speed_d = {pinLvl[sdg_pkg::PIN_STRAP],
						pinLvl[sdg_pkg::PIN_MSTR]}; // [R11] [R12]
					strap_d = sdg_pkg::ST_DRIVE; // [R13]
				end else begin
					settle_d = settle_q + 3'h1;
				end
			end
			sdg_pkg::ST_DRIVE: begin
				strap_d = sdg_pkg::ST_DRIVE;
			end
			default: begin
				strap_d = sdg_pkg::ST_SETTLE;
			end
		endcase
	end

	// gate term and gated address bit
	always_comb begin
		gateOn = pinLvl[sdg_pkg::PIN_KBC] |
			(sysCtrlA[sdg_pkg::ALT_GATE_BIT] & cpuOwnsBus); // [R14]
		gate_d = gateOn;
		if (cpuGenAddr) begin
			bit20_d = cpuBus.addr[sdg_pkg::GATE_ADDR_BIT] &
				gateOn; // [R10]
		end else begin
			bit20_d = cpuBus.addr[sdg_pkg::GATE_ADDR_BIT];
		end
	end

	// strap and gate registers
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			strap_q <= sdg_pkg::ST_SETTLE;
			settle_q <= 3'h0;
			speed_q <= sdg_pkg::SPEED_RST;
			gate_q <= 1'b0;
			bit20_q <= 1'b0;
		end else begin
			strap_q <= strap_d;
			settle_q <= settle_d;
			speed_q <= speed_d;
			gate_q <= gate_d;
			bit20_q <= bit20_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// parity enable mirror and test tristate

	logic parEn_q, parEn_d, testOff;

	// mirror of the parity enable bit
	always_comb begin
		parEn_d = memEncReg[sdg_pkg::PAR_EN_BIT]; // [R15]
	end

	// parity enable register
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			parEn_q <= 1'b0;
		end else begin
			parEn_q <= parEn_d;
		end
	end

	// test low releases every driven line
	assign testOff = ~pinLvl[sdg_pkg::PIN_TEST]; // [R16]
	assign outputsOe = ~testOff; // [R17]
	assign addrGateStrapOe = ~testOff &
		(strap_q == sdg_pkg::ST_DRIVE); // [R13] [R16]

	////////////////////////////////////////////////////////////////////
	// outputs

	assign video_window_sel = videoSel_q;
	assign setup_data_reg_sel = setupSel_q;
	assign card_setup_sel = cardSel_q;
	assign phys_addr_bit20 = bit20_q;
	assign parity_check_en_out = parEn_q;
	assign addrGateStrapOut = gate_q; // [R13]
	assign speedSel = speed_q;
	assign latchArmed = armed_q;
endmodule
`default_nettype wire

// file: rtl/sdg_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sdg_pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic sysClk, // system clock
	input wire logic resetn, // async reset, low
	input wire logic [W-1:0] pinIn, // raw pins
	output logic [W-1:0] level, // filtered level
	output logic [W-1:0] rise // one cycle on rising change
);
	logic [W-1:0] s1_q, s2_q, s3_q, level_q, rise_q;
	logic [W-1:0] level_d, rise_d;

	// level moves only when stages two and three agree
	always_comb begin
		level_d = (s2_q & s3_q) | (level_q & (s2_q ^ s3_q));
		rise_d = level_d & ~level_q;
	end

	// three stage chain plus filtered state
	always_ff @(posedge sysClk or negedge resetn) begin
		if (!resetn) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			level_q <= RST_VAL;
			rise_q <= '0;
		end else begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= level_d;
			rise_q <= rise_d;
		end
	end

	assign level = level_q;
	assign rise = rise_q;
endmodule
`default_nettype wire

// file: rtl/sdg_state_capture.sv
`timescale 1ns/10ps
`default_nettype none
module sdg_state_capture #(
	parameter int W = 8
) (
	input wire logic sysClk, // system clock
	input wire logic resetn, // async reset, low
	input wire logic capture, // take a snapshot
	input wire logic [W-1:0] dataIn, // live state
	output logic [W-1:0] dataOut, // held snapshot
	output logic valid // a snapshot is held
);
	logic [W-1:0] data_q, data_d;
	logic valid_q, valid_d;

	// hold unless a capture is requested
	always_comb begin
		data_d = capture ? dataIn : data_q;
		valid_d = valid_q | capture;
	end

	// snapshot register
	always_ff @(posedge sysClk or negedge resetn) begin
		if (!resetn) begin
			data_q <= '0;
			valid_q <= 1'b0;
		end else begin
			data_q <= data_d;
			valid_q <= valid_d;
		end
	end

	assign dataOut = data_q;
	assign valid = valid_q;
endmodule
`default_nettype wire

// file: shared/sdg_pkg.sv
`default_nettype none
package sdg_pkg;
	// local bus cycle seen on the processor side
	typedef struct packed {
		logic cycleValid; // address phase qualifier
		logic mio; // memory when high, io when low
		logic dc; // data cycle when high
		logic wr; // write when high
		logic [31:0] addr; // byte address
	} sdg_bus_s;

	localparam int BUS_W = 36;

	// strap sequencing after reset release
	typedef enum logic [1:0] {
		ST_SETTLE = 2'b00,
		ST_DRIVE = 2'b01
	} sdg_strap_e;

	// video memory window
	localparam logic [31:0] VID_BASE = 32'h000a0000;
	localparam logic [31:0] VID_LAST = 32'h000bffff;
	localparam int VID_EN_BIT = 0;

	// card setup io range
	localparam logic [15:0] CARD_BASE = 16'h0100;
	localparam logic [15:0] CARD_LAST = 16'h0107;

	// alternate gate bit in system control port a
	localparam int ALT_GATE_BIT = 1;
	// parity check bit in memory encoding register
	localparam int PAR_EN_BIT = 0;
	// address bit that the gate controls
	localparam int GATE_ADDR_BIT = 20;

	// synchronised pin vector layout
	localparam int PIN_W = 7;
	localparam int PIN_CHRST = 0;
	localparam int PIN_CHAN_CHECK_IN = 1;
	localparam int PIN_CMD = 2;
	localparam int PIN_KBC = 3;
	localparam int PIN_STRAP = 4;
	localparam int PIN_MSTR = 5;
	localparam int PIN_TEST = 6;
	localparam logic [6:0] PIN_RST_VAL = 7'h00;

	// cycles after release before straps are taken (sync depth plus filter)
	localparam logic [2:0] STRAP_SETTLE_CYC = 3'h4;

	// reset values
	localparam logic [1:0] SPEED_RST = 2'h0;
endpackage
`default_nettype wire
